//--- src/sync_receive_framing_parity.sv
// How it works
// R1: bit counter loads its start value from aux register bits 8 to 11.
// R2: sync seen while hunting sets first-sync on next falling receive clock.
// R3: once first-sync is set, the hunt no longer clocks either sync flag.
// R4: while the load term is on, the bit counter loads and never counts.
// R5: delay flag sets on next rising receive clock after first-sync; counting starts after.
// R6: counting past the last bit gives a carry that reloads the counter.
// R7: carry starts a 100 ns buffer load pulse for the receive buffer.
// R8: 50 ns control pulse follows; its end sets framed on a second sync.
// R9: framed set blocks any further clocking of both sync flags.
// R10: after-data option sets active on first non-sync; set path closes 500 ns later.
// R11: without after-data option, active sets as soon as framed sets.
// R12: with one-sync framing, one sync sets first-sync and framed together.
// R13: sync flags stay set after framing until the reset logic clears them.
// R14: writing one to control bit 12 gives a 50 ns pulse presetting both flags.
// R15: init, software clear of active, go falling or recognition clear reset all.
// R16: clearing active makes a 50 ns pulse clearing flags, active and counter.
// R17: go falling makes the same clearing pulse as clearing active.
// R18: parity tracker follows mark bits; even option selects even parity.
// R19: parity checked at buffer load only if enabled, first-sync set, no block check.
// R20: a parity mismatch sets error bit 7; good parity leaves it alone.
// R21: the carry clears the parity tracker for the next character.
// R22: one-shots and delays are counted strobes on the system clock, same order.
`timescale 1ns/1ps
module sync_receive_framing_parity (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// serial line
	input  wire logic        rx_clock_pin,
	input  wire logic        rx_data_pin,
	// companion logic
	input  wire logic        sync_char_detected,
	input  wire logic        recognition_clear,
	input  wire logic        block_check_active,
	input  wire logic        init_clear,
	// framing outputs
	output logic             buffer_load_pulse,
	output logic             framing_control_pulse,
	output logic             receive_active,
	output logic             parity_error_flag
);
	import sync_rx_framing_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// run a pulse timer down to zero
	function automatic logic [PULSE_W-1:0] pulse_dec(input logic [PULSE_W-1:0] c);
		pulse_dec = (c == '0) ? '0 : PULSE_W'(c - 1'b1);
	endfunction

	// ----------------------------------------
	// line input synchronisers
	// ----------------------------------------
	logic rxc_s1_reg;
	logic rxc_s2_reg;
	logic rxc_s3_reg;
	logic rxd_s1_reg;
	logic rxd_s2_reg;
	logic rx_rise;
	logic rx_fall;

	// two flops per pin, third only for edge finding
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rxc_s1_reg <= 1'b0;
			rxc_s2_reg <= 1'b0;
			rxc_s3_reg <= 1'b0;
			rxd_s1_reg <= 1'b0;
			rxd_s2_reg <= 1'b0;
		end else begin
			rxc_s1_reg <= rx_clock_pin;
			rxc_s2_reg <= rxc_s1_reg;
			rxc_s3_reg <= rxc_s2_reg;
			rxd_s1_reg <= rx_data_pin;
			rxd_s2_reg <= rxd_s1_reg;
		end
	end

	assign rx_rise = rxc_s2_reg & ~rxc_s3_reg;
	assign rx_fall = ~rxc_s2_reg & rxc_s3_reg;

	// ----------------------------------------
	// bus data phase
	// ----------------------------------------
	logic              sel_reg;
	logic              sel_next;
	logic              wr_reg;
	logic              wr_next;
	logic [REG_AW-1:0] addr_reg;
	logic [REG_AW-1:0] addr_next;
	logic              wr_ctrl;
	logic              wr_aux;
	logic              wr_err;

	// capture address phase when the bus is ready
	always_comb begin
		sel_next  = hsel & htrans[1] & hready;
		wr_next   = hsel & htrans[1] & hready & hwrite;
		addr_next = addr_reg;
		if (hsel & htrans[1] & hready) begin
			addr_next = haddr[REG_AW-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_reg  <= 1'b0;
			wr_reg   <= 1'b0;
			addr_reg <= '0;
		end else begin
			sel_reg  <= sel_next;
			wr_reg   <= wr_next;
			addr_reg <= addr_next;
		end
	end

	assign wr_ctrl   = wr_reg & (addr_reg == ADDR_CTRL);
	assign wr_aux    = wr_reg & (addr_reg == ADDR_AUX);
	assign wr_err    = wr_reg & (addr_reg == ADDR_ERR);
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	logic             go_reg;
	logic             go_next;
	logic             two_sync_reg;
	logic             two_sync_next;
	logic             after_data_reg;
	logic             after_data_next;
	logic             even_reg;
	logic             even_next;
	logic             par_en_reg;
	logic             par_en_next;
	logic [BPC_W-1:0] bpc_reg;
	logic [BPC_W-1:0] bpc_next;
	logic             mclr;

	// software writes of go and options
	always_comb begin
		go_next         = go_reg;
		two_sync_next   = two_sync_reg;
		after_data_next = after_data_reg;
		even_next       = even_reg;
		par_en_next     = par_en_reg;
		bpc_next        = bpc_reg;
		if (wr_ctrl) begin
			go_next = hwdata[CTRL_GO_BIT];
		end
		if (wr_aux) begin
			two_sync_next   = hwdata[AUX_TWO_SYNC_BIT];
			after_data_next = hwdata[AUX_AFTER_DATA_BIT];
			even_next       = hwdata[AUX_EVEN_BIT];
			par_en_next     = hwdata[AUX_PAR_EN_BIT];
			bpc_next        = hwdata[AUX_BPC_LSB +: BPC_W]; // R1
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			go_reg         <= 1'b0;
			two_sync_reg   <= 1'b0;
			after_data_reg <= 1'b0;
			even_reg       <= 1'b0;
			par_en_reg     <= 1'b0;
			bpc_reg        <= BPC_RESET;
		end else begin
			go_reg         <= go_next;
			two_sync_reg   <= two_sync_next;
			after_data_reg <= after_data_next;
			even_reg       <= even_next;
			par_en_reg     <= par_en_next;
			bpc_reg        <= bpc_next;
		end
	end

	// master clear is a self-clearing write strobe
	assign mclr = wr_aux & hwdata[AUX_MCLR_BIT];

	// ----------------------------------------
	// start up, counter and parity
	// ----------------------------------------
	logic               sync1_reg;
	logic               sync1_next;
	logic               framed_reg;
	logic               framed_next;
	logic               delay_reg;
	logic               delay_next;
	logic               active_reg;
	logic               active_next;
	logic               inhibit_reg;
	logic               inhibit_next;
	logic [INH_W-1:0]   inh_cnt_reg;
	logic [INH_W-1:0]   inh_cnt_next;
	logic [BPC_W-1:0]   cnt_reg;
	logic [BPC_W-1:0]   cnt_next;
	logic [PULSE_W-1:0] ldbuf_cnt_reg;
	logic [PULSE_W-1:0] ldbuf_cnt_next;
	logic [PULSE_W-1:0] ctrl_cnt_reg;
	logic [PULSE_W-1:0] ctrl_cnt_next;
	logic [PULSE_W-1:0] force_cnt_reg;
	logic [PULSE_W-1:0] force_cnt_next;
	logic [PULSE_W-1:0] clr_cnt_reg;
	logic [PULSE_W-1:0] clr_cnt_next;
	logic               go_prev_reg;
	logic               tracker_reg;
	logic               tracker_next;
	logic               err_reg;
	logic               err_next;
	logic               sw_set_active;
	logic               sw_clr_active;
	logic               clr_cause;
	logic               clr_now;
	logic               hunt_set;
	logic               ctrl_end;
	logic               carry_now;
	logic               par_check;
	logic               par_final;
	logic               par_bad;
	logic               active_set_path;

	// event terms
	assign sw_set_active = wr_ctrl & hwdata[CTRL_ACTIVE_BIT] & ~active_reg;
	assign sw_clr_active = wr_ctrl & ~hwdata[CTRL_ACTIVE_BIT] & active_reg;
	assign clr_cause     = init_clear | mclr | recognition_clear | sw_clr_active
		| (go_prev_reg & ~go_reg); // R15 R17
	assign clr_now       = clr_cause | (clr_cnt_reg != '0);
	assign hunt_set      = rx_fall & ~sync1_reg & ~framed_reg & (ctrl_cnt_reg == '0)
		& sync_char_detected & ~clr_now; // R2 R3 R9
	assign ctrl_end      = (ctrl_cnt_reg == PULSE_W'(1));
	assign carry_now     = rx_rise & delay_reg & (cnt_reg == 4'hf) & ~clr_now; // R6
	assign par_final     = tracker_reg ^ rxd_s2_reg;
	assign par_bad       = even_reg ? par_final : ~par_final; // R18
	assign par_check     = carry_now & par_en_reg & sync1_reg & ~block_check_active; // R19
	assign active_set_path = framed_reg & ~active_reg & ~inhibit_reg
		& (after_data_reg ? ~sync_char_detected : 1'b1); // R10 R11

	// next state of the framing logic
	always_comb begin
		sync1_next     = sync1_reg;
		framed_next    = framed_reg;
		delay_next     = delay_reg;
		active_next    = active_reg;
		inhibit_next   = inhibit_reg;
		inh_cnt_next   = inh_cnt_reg;
		cnt_next       = cnt_reg;
		tracker_next   = tracker_reg;
		err_next       = err_reg;
		ldbuf_cnt_next = pulse_dec(ldbuf_cnt_reg); // R22
		ctrl_cnt_next  = pulse_dec(ctrl_cnt_reg);
		force_cnt_next = pulse_dec(force_cnt_reg);
		clr_cnt_next   = pulse_dec(clr_cnt_reg);
		// load pulse then control pulse
		if (ldbuf_cnt_reg == PULSE_W'(1)) begin
			ctrl_cnt_next = CTRL_CYC; // R8
		end
		if (carry_now) begin
			ldbuf_cnt_next = LOAD_PULSE_CYC; // R7
		end
		// hunt on the steered clock
		if (hunt_set) begin
			sync1_next = 1'b1; // R2
			if (!two_sync_reg) begin
				framed_next = 1'b1; // R12
			end
		end
		if (ctrl_end && sync1_reg && !framed_reg && two_sync_reg && sync_char_detected) begin
			framed_next = 1'b1; // R8
		end
		// one receive clock of delay before counting
		if (rx_rise && sync1_reg) begin
			delay_next = 1'b1; // R5
		end
		// bit counter
		if (rx_rise) begin
			if (!delay_reg) begin
				cnt_next = bpc_reg; // R4
			end else if (cnt_reg == 4'hf) begin
				cnt_next = bpc_reg; // R6
			end else begin
				cnt_next = BPC_W'(cnt_reg + 1'b1);
			end
		end
		// ones tracker over counted bits
		if (rx_rise && delay_reg && rxd_s2_reg) begin
			tracker_next = ~tracker_reg; // R18
		end
		if (carry_now) begin
			tracker_next = 1'b0; // R21
		end
		// error flag: write one clears, set wins
		if (wr_err && hwdata[ERR_PARITY_BIT]) begin
			err_next = 1'b0;
		end
		if (par_check && par_bad) begin
			err_next = 1'b1; // R20
		end
		// receive active and its set path inhibit
		if (active_set_path) begin
			active_next = 1'b1; // R10 R11
		end
		if (active_reg && !inhibit_reg) begin
			inh_cnt_next = INH_W'(inh_cnt_reg + 1'b1);
			if (inh_cnt_reg == INH_W'(ACT_INH_CYC - 1'b1)) begin
				inhibit_next = 1'b1; // R10
			end
		end
		// force framing by software
		if (sw_set_active) begin
			active_next    = 1'b1;
			force_cnt_next = FORCE_CYC; // R14
		end
		if (force_cnt_reg != '0) begin
			sync1_next  = 1'b1; // R14
			framed_next = 1'b1;
		end
		// reset logic overrides everything it clears
		if (clr_cause) begin
			clr_cnt_next = CLR_CYC; // R16
		end
		if (clr_now) begin
			sync1_next     = 1'b0; // R13 R16
			framed_next    = 1'b0;
			delay_next     = 1'b0;
			active_next    = 1'b0;
			inhibit_next   = 1'b0;
			inh_cnt_next   = '0;
			cnt_next       = '0;
			tracker_next   = 1'b0;
			ldbuf_cnt_next = '0;
			ctrl_cnt_next  = '0;
			force_cnt_next = '0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_reg     <= 1'b0;
			framed_reg    <= 1'b0;
			delay_reg     <= 1'b0;
			active_reg    <= 1'b0;
			inhibit_reg   <= 1'b0;
			inh_cnt_reg   <= '0;
			cnt_reg       <= '0;
			tracker_reg   <= 1'b0;
			err_reg       <= 1'b0;
			ldbuf_cnt_reg <= '0;
			ctrl_cnt_reg  <= '0;
			force_cnt_reg <= '0;
			clr_cnt_reg   <= '0;
			go_prev_reg   <= 1'b0;
		end else begin
			sync1_reg     <= sync1_next;
			framed_reg    <= framed_next;
			delay_reg     <= delay_next;
			active_reg    <= active_next;
			inhibit_reg   <= inhibit_next;
			inh_cnt_reg   <= inh_cnt_next;
			cnt_reg       <= cnt_next;
			tracker_reg   <= tracker_next;
			err_reg       <= err_next;
			ldbuf_cnt_reg <= ldbuf_cnt_next;
			ctrl_cnt_reg  <= ctrl_cnt_next;
			force_cnt_reg <= force_cnt_next;
			clr_cnt_reg   <= clr_cnt_next;
			go_prev_reg   <= go_reg;
		end
	end

	// ----------------------------------------
	// outputs and read mux
	// ----------------------------------------
	assign buffer_load_pulse     = (ldbuf_cnt_reg != '0);
	assign framing_control_pulse = (ctrl_cnt_reg != '0);
	assign receive_active        = active_reg;
	assign parity_error_flag     = err_reg;

	// zero wait read from register flops, unmapped reads zero
	always_comb begin
		hrdata = 32'h0;
		if (sel_reg && !wr_reg) begin
			case (addr_reg)
				ADDR_CTRL: begin
					hrdata[CTRL_GO_BIT]     = go_reg;
					hrdata[CTRL_ACTIVE_BIT] = active_reg;
				end
				ADDR_AUX: begin
					hrdata[AUX_TWO_SYNC_BIT]        = two_sync_reg;
					hrdata[AUX_AFTER_DATA_BIT]      = after_data_reg;
					hrdata[AUX_EVEN_BIT]            = even_reg;
					hrdata[AUX_PAR_EN_BIT]          = par_en_reg;
					hrdata[AUX_BPC_LSB +: BPC_W]    = bpc_reg;
				end
				ADDR_ERR: begin
					hrdata[ERR_PARITY_BIT] = err_reg;
				end
				ADDR_STAT: begin
					hrdata[STAT_SYNC1_BIT]          = sync1_reg;
					hrdata[STAT_FRAMED_BIT]         = framed_reg;
					hrdata[STAT_DELAY_BIT]          = delay_reg;
					hrdata[STAT_ACTIVE_BIT]         = active_reg;
					hrdata[STAT_INHIBIT_BIT]        = inhibit_reg;
					hrdata[STAT_CNT_LSB +: BPC_W]   = cnt_reg;
				end
				default: hrdata = 32'h0;
			endcase
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	localparam int INH_MAX = 60;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	chk_hunt_sets_flags: assert property (hunt_set |=> sync1_reg && // R2 R12
		(framed_reg == !$past(two_sync_reg)))
		else $error("hunt did not set sync flags");
	chk_load_no_count: assert property ((rx_rise && !delay_reg && !clr_now) // R4
		|=> cnt_reg == $past(bpc_reg))
		else $error("counter counted during load");
	chk_delay_after_sync: assert property ($rose(delay_reg) |-> $past(sync1_reg)) // R5
		else $error("delay set without first sync");
	chk_carry_load_buf: assert property (carry_now |=> // R6 R7
		(ldbuf_cnt_reg == LOAD_PULSE_CYC) && (cnt_reg == $past(bpc_reg)) && !tracker_reg)
		else $error("carry did not start load pulse");
	chk_ctrl_follows: assert property ((ldbuf_cnt_reg == PULSE_W'(1)) && !clr_now // R8
		|=> ctrl_cnt_reg == CTRL_CYC && !buffer_load_pulse)
		else $error("control pulse did not follow load pulse");
	chk_framed_holds: assert property (framed_reg && !clr_now |=> framed_reg && sync1_reg) // R13
		else $error("framed dropped without reset");
	chk_no_hunt_framed: assert property (sync1_reg && !framed_reg && rx_fall && !ctrl_end // R3 R9
		&& (force_cnt_reg == '0) && !clr_now |=> !framed_reg)
		else $error("hunt clocked after first sync");
	chk_active_framed: assert property (framed_reg && !after_data_reg && !clr_now // R11
		|=> active_reg)
		else $error("active not set on framing");
	chk_inhibit_time: assert property ($rose(active_reg) ##1 (!clr_now)[*8] // R10
		|-> ##[1:INH_MAX] (inhibit_reg || clr_now))
		else $error("active set path not inhibited");
	chk_force_frame: assert property (sw_set_active && !clr_now // R14
		|=> ##1 (sync1_reg && framed_reg))
		else $error("force framing failed");
	chk_clear_pulse: assert property (clr_cause |=> // R15 R16 R17
		(!sync1_reg && !framed_reg && !active_reg && cnt_reg == '0)[*5])
		else $error("reset logic did not clear");
	chk_parity_err: assert property (par_check && par_bad |=> err_reg) // R20 R19
		else $error("parity error not flagged");

	cov_framed:   cover property ($rose(framed_reg));
	cov_active:   cover property ($rose(active_reg) && after_data_reg);
	cov_par_err:  cover property ($rose(err_reg));
	cov_go_clear: cover property (go_prev_reg && !go_reg && framed_reg);

endmodule

//--- src/sync_rx_framing_pkg.sv
package sync_rx_framing_pkg;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam int         REG_AW    = 8;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_AUX  = 8'h04;
	localparam logic [7:0] ADDR_ERR  = 8'h08;
	localparam logic [7:0] ADDR_STAT = 8'h0c;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTRL_GO_BIT        = 0;
	localparam int CTRL_ACTIVE_BIT    = 12;
	localparam int AUX_TWO_SYNC_BIT   = 0;
	localparam int AUX_AFTER_DATA_BIT = 1;
	localparam int AUX_EVEN_BIT       = 2;
	localparam int AUX_PAR_EN_BIT     = 3;
	localparam int AUX_MCLR_BIT       = 5;
	localparam int AUX_BPC_LSB        = 8;
	localparam int BPC_W              = 4;
	localparam int ERR_PARITY_BIT     = 7;
	localparam int STAT_SYNC1_BIT     = 0;
	localparam int STAT_FRAMED_BIT    = 1;
	localparam int STAT_DELAY_BIT     = 2;
	localparam int STAT_ACTIVE_BIT    = 3;
	localparam int STAT_INHIBIT_BIT   = 4;
	localparam int STAT_CNT_LSB       = 8;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [BPC_W-1:0] BPC_RESET = 4'h0;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int LOAD_PULSE_NS = 100;
	localparam int CTRL_PULSE_NS = 50;
	localparam int FORCE_NS      = 50;
	localparam int CLR_NS        = 50;
	localparam int ACT_INH_NS    = 500;
	localparam int PULSE_W       = 4;
	localparam int INH_W         = 6;
	localparam logic [PULSE_W-1:0] LOAD_PULSE_CYC =
		PULSE_W'((LOAD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [PULSE_W-1:0] CTRL_CYC =
		PULSE_W'((CTRL_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [PULSE_W-1:0] FORCE_CYC =
		PULSE_W'((FORCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [PULSE_W-1:0] CLR_CYC =
		PULSE_W'((CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [INH_W-1:0] ACT_INH_CYC =
		INH_W'((ACT_INH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

//--- verification/modem_line_model.sv
`timescale 1ns/1ps
module modem_line_model (
	// frame control from the bench
	input  wire logic       run,
	input  wire logic [7:0] pattern,
	// serial line towards the block
	output logic            rx_clock_pin,
	output logic            rx_data_pin
);
	logic [2:0] idx;
	logic       last;

	// ----------------------------------------
	// line driver
	// ----------------------------------------
	// clock stands low between frames, data shows the inverse of the last bit
	initial begin
		rx_clock_pin = 1'b0;
		rx_data_pin  = 1'b1;
		idx          = 3'h0;
		last         = 1'b0;
		#3.3;
		forever begin
			if (run) begin
				rx_data_pin = pattern[idx]; // data moves just after the falling edge
				last        = pattern[idx];
				idx         = idx + 3'h1; // lsb first, pattern repeats
				#40 rx_clock_pin = 1'b1;
				#40 rx_clock_pin = 1'b0;
			end else begin
				rx_data_pin = ~last;
				#40;
			end
		end
	end
endmodule

//--- verification/tb_sync_receive_framing_parity.sv
`timescale 1ns/1ps
module tb_sync_receive_framing_parity;
	import sync_rx_framing_pkg::*;

	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        rx_clock_pin;
	logic        rx_data_pin;
	logic        run;
	logic [7:0]  pattern;
	logic        sync_det;
	logic        rcl;
	logic        bca;
	logic        init_clr;
	logic        buffer_load_pulse;
	logic        framing_control_pulse;
	logic        receive_active;
	logic        parity_error_flag;
	int          checks;
	int          mismatches;

	// ----------------------------------------
	// design and line partner
	// ----------------------------------------
	sync_receive_framing_parity DUT (
		.hclk                  (hclk),
		.hresetn               (hresetn),
		.hsel                  (hsel),
		.haddr                 (haddr),
		.htrans                (htrans),
		.hwrite                (hwrite),
		.hsize                 (hsize),
		.hwdata                (hwdata),
		.hready                (hreadyout),
		.hrdata                (hrdata),
		.hreadyout             (hreadyout),
		.hresp                 (hresp),
		.rx_clock_pin          (rx_clock_pin),
		.rx_data_pin           (rx_data_pin),
		.sync_char_detected    (sync_det),
		.recognition_clear     (rcl),
		.block_check_active    (bca),
		.init_clear            (init_clr),
		.buffer_load_pulse     (buffer_load_pulse),
		.framing_control_pulse (framing_control_pulse),
		.receive_active        (receive_active),
		.parity_error_flag     (parity_error_flag)
	);

	modem_line_model modem (
		.run          (run),
		.pattern      (pattern),
		.rx_clock_pin (rx_clock_pin),
		.rx_data_pin  (rx_data_pin)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask

	// one single ahb-lite transfer, called just after a rising edge
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input string n);
		logic [31:0] q;
		bus(a, 1'b0, 32'h0, q);
		chk(n, e, q & m);
	endtask

	task automatic wait_load();
		int n;
		n = 0;
		// let a pulse already under way pass, then wait for a fresh one
		while (buffer_load_pulse === 1'b1 && n < 500) begin
			@(posedge hclk);
			n++;
		end
		while (buffer_load_pulse !== 1'b1 && n < 500) begin
			@(posedge hclk);
			n++;
		end
	endtask

	// pulse widths after a carry, then optional gap to the next carry
	task automatic frame_char(input int gap);
		int n;
		int w;
		int c;
		wait_load();
		n = 0;
		w = 0;
		c = 0;
		while (buffer_load_pulse === 1'b1 && w < 50) begin
			@(posedge hclk);
			n++;
			w++;
		end
		while (framing_control_pulse === 1'b1 && c < 50) begin
			@(posedge hclk);
			n++;
			c++;
		end
		chk("load width", 32'(10), 32'(w));
		chk("control width", 32'(5), 32'(c));
		if (gap > 0) begin
			while (buffer_load_pulse !== 1'b1 && n < 500) begin
				@(posedge hclk);
				n++;
			end
			chk("char gap", 32'(gap), 32'(n));
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ----------------------------------------
	// clock and watchdog
	// ----------------------------------------
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	initial begin
		#200000;
		mismatches++;
		test_done();
	end

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		checks = 0;
		mismatches = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		run = 1'b0;
		pattern = 8'h07;
		sync_det = 1'b0;
		rcl = 1'b0;
		bca = 1'b1;
		init_clr = 1'b0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// reset values and an unmapped place
		for (int a = 0; a <= 16; a += 4) rd(8'(a), 32'hffffffff, 32'h0, "reset value");
		wr(8'h10, 32'hffffffff);
		rd(8'h10, 32'hffffffff, 32'h0, "unmapped");
		// one sync, active on framing, even parity with block check first
		wr(ADDR_AUX, 32'h0000080c);
		wr(ADDR_CTRL, 32'h00000001);
		sync_det <= 1'b1;
		run <= 1'b1;
		frame_char(64);
		rd(ADDR_STAT, 32'h0000000f, 32'h0000000f, "one sync framing");
		rd(ADDR_ERR, 32'hffffffff, 32'h0, "parity under block check");
		bca <= 1'b0;
		frame_char(0);
		rd(ADDR_ERR, 32'hffffffff, 32'h00000080, "even parity error");
		chk("error pin", 32'h1, {31'h0, parity_error_flag});
		pattern <= 8'h03;
		frame_char(0);
		frame_char(0);
		wr(ADDR_ERR, 32'h00000080);
		frame_char(0);
		rd(ADDR_ERR, 32'hffffffff, 32'h0, "good parity");
		chk("error pin", 32'h0, {31'h0, parity_error_flag});
		wr(ADDR_AUX, 32'h00000808);
		sync_det <= 1'b0;
		frame_char(0);
		rd(ADDR_ERR, 32'hffffffff, 32'h00000080, "odd parity error");
		rd(ADDR_STAT, 32'h0000000f, 32'h0000000f, "flags held");
		// software clear of active
		run <= 1'b0;
		repeat (12) @(posedge hclk);
		wr(ADDR_CTRL, 32'h00000001);
		repeat (8) @(posedge hclk);
		rd(ADDR_STAT, 32'h00000f0f, 32'h0, "active clear");
		chk("active pin", 32'h0, {31'h0, receive_active});
		// force framing, then each clearing cause; go falls last
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_CTRL, 32'h00001001);
			repeat (8) @(posedge hclk);
			rd(ADDR_STAT, 32'h0000000b, 32'h0000000b, "forced framing");
			if (i == 0) init_clr <= 1'b1;
			if (i == 1) rcl <= 1'b1;
			if (i == 2) wr(ADDR_AUX, 32'h00000020);
			if (i == 3) wr(ADDR_CTRL, 32'h00001000);
			@(posedge hclk);
			init_clr <= 1'b0;
			rcl <= 1'b0;
			repeat (8) @(posedge hclk);
			rd(ADDR_STAT, 32'h0000000f, 32'h0, "cleared by cause");
		end
		rd(ADDR_AUX, 32'h00000020, 32'h0, "master clear reads zero");
		// two syncs, active after data, six bit characters
		wr(ADDR_AUX, 32'h00000a03);
		wr(ADDR_CTRL, 32'h00000001);
		sync_det <= 1'b1;
		run <= 1'b1;
		wait_load();
		rd(ADDR_STAT, 32'h0000000f, 32'h00000005, "first sync only");
		repeat (20) @(posedge hclk);
		rd(ADDR_STAT, 32'h0000000f, 32'h00000007, "framed, waiting data");
		sync_det <= 1'b0;
		repeat (3) @(posedge hclk);
		rd(ADDR_STAT, 32'h0000000f, 32'h0000000f, "active on data");
		chk("active pin", 32'h1, {31'h0, receive_active});
		repeat (60) @(posedge hclk);
		rd(ADDR_STAT, 32'h00000010, 32'h00000010, "set path closed");
		frame_char(48);
		run <= 1'b0;
		repeat (12) @(posedge hclk);
		test_done();
	end
endmodule
